// file: rtl/scp_pkg.sv
package scp_pkg;

  // apb register byte addresses
  localparam logic [11:0] ADDR_TRIM   = 12'h000;
  localparam logic [11:0] ADDR_CTRL   = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // divider control field positions
  localparam int CTRL_PCE_BIT  = 7;
  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_SEL_W    = 4;

  // status field positions
  localparam int STAT_SEL_LSB  = 0;
  localparam int STAT_TGT_LSB  = 4;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_INIT_BIT = 9;

  // division select codes and reset values
  localparam logic [3:0] SEL_DIV1    = 4'h0;
  localparam logic [3:0] SEL_DIV8    = 4'h3;
  localparam logic [3:0] SEL_MAX     = 4'h8;
  localparam logic [7:0] TRIM_RESET  = 8'h00;
  localparam logic [7:0] CNT_RESET   = 8'h00;

  // change-enable window, in divided clock cycles
  localparam int         PCE_WINDOW_CYCLES = 4;
  localparam logic [2:0] PCE_WINDOW        = 3'(PCE_WINDOW_CYCLES);
  localparam logic [2:0] PCE_CLOSED        = 3'h0;

  // master clock
  localparam real CLK_PERIOD_NS = 4.0;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OLD  = 3'b010,
    SW_NEW  = 3'b100
  } scp_sw_state_t;

endpackage

// file: rtl/scp_prescaler.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module scp_prescaler
(
  // clock and resets
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        powerOnRst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // fuses and factory data
  input  wire logic        clockOutputFuse,
  input  wire logic        divideByEightFuse,
  input  wire logic [7:0]  factoryTrim,
  // port function sharing the clock output pin
  input  wire logic        portDataOut,
  input  wire logic        portOeN,
  // clock outputs and oscillator trim
  output logic [3:0]       domainTick,
  output logic             clockOutPin,
  output logic             clockOutPinOeN,
  output logic [7:0]       rcOscTrim
);
  import scp_pkg::*;

  // apb front end
  logic        setup;
  logic        access;
  logic        wrTrim;
  logic        wrCtrl;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  // control state
  logic [7:0]    trim_r;
  logic [7:0]    trim_nxt;
  logic [3:0]    tgtSel_r;
  logic [3:0]    tgtSel_nxt;
  logic [3:0]    curSel_r;
  logic [3:0]    curSel_nxt;
  logic [2:0]    pceCnt_r;
  logic [2:0]    pceCnt_nxt;
  logic [7:0]    cnt_r;
  logic [7:0]    cnt_nxt;
  logic          initDone_r;
  logic          initDone_nxt;
  scp_sw_state_t swState_r;
  scp_sw_state_t swState_nxt;
  logic [3:0]    domainTick_r;
  logic [3:0]    domainTick_nxt;

  logic       pceOpen;
  logic       cleanPce;
  logic       selWrite;
  logic       accept;
  logic [7:0] mask;
  logic       tickNow;

  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready_r;
  assign wrTrim  = access & pwrite & (paddr == ADDR_TRIM);
  assign wrCtrl  = access & pwrite & (paddr == ADDR_CTRL);
  assign pceOpen = (pceCnt_r != PCE_CLOSED);

  assign cleanPce = pwdata[CTRL_PCE_BIT] & (pwdata[CTRL_PCE_BIT-1:0] == 7'h00);
  assign selWrite = wrCtrl & ~pwdata[CTRL_PCE_BIT];
  // reserved codes are dropped, the divider keeps its factor
  assign accept   = selWrite & pceOpen & (pwdata[3:0] <= SEL_MAX);

  // period mask: 2**sel master cycles per divided cycle
  assign mask    = 8'((9'h001 << curSel_r) - 9'h001);
  assign tickNow = ((cnt_r & mask) == mask);

  // apb answer: decoded in setup, shown in the single access cycle
  always_comb begin
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt  = setup;
    if (setup) begin
      if (paddr == ADDR_TRIM) begin
        prdata_nxt[7:0] = trim_r;
      end else if (paddr == ADDR_CTRL) begin
        prdata_nxt[CTRL_PCE_BIT]                   = pceOpen;
        prdata_nxt[CTRL_SEL_LSB +: CTRL_SEL_W]     = tgtSel_r;
      end else if (paddr == ADDR_STATUS) begin
        // count state stays hidden; only the current and target factors and the busy and init flags show
        prdata_nxt[STAT_SEL_LSB +: CTRL_SEL_W] = curSel_r;
        prdata_nxt[STAT_TGT_LSB +: CTRL_SEL_W] = tgtSel_r;
        prdata_nxt[STAT_BUSY_BIT]              = (swState_r != SW_IDLE);
        prdata_nxt[STAT_INIT_BIT]              = initDone_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // registers, change-enable window and divider switch sequence
  always_comb begin
    trim_nxt     = trim_r;
    tgtSel_nxt   = tgtSel_r;
    curSel_nxt   = curSel_r;
    pceCnt_nxt   = pceCnt_r;
    initDone_nxt = 1'b1;
    swState_nxt  = swState_r;
    cnt_nxt      = tickNow ? CNT_RESET : 8'(cnt_r + 8'h01);
    if (!initDone_r) begin
      // straps are caught on the first edge after reset release
      trim_nxt   = factoryTrim;
      tgtSel_nxt = divideByEightFuse ? SEL_DIV8 : SEL_DIV1;
      curSel_nxt = divideByEightFuse ? SEL_DIV8 : SEL_DIV1;
    end else begin
      if (wrTrim) begin
        trim_nxt = pwdata[7:0];
      end
      if (pceOpen && tickNow) begin
        pceCnt_nxt = 3'(pceCnt_r - 3'h1);
      end
      if (wrCtrl && cleanPce && !pceOpen) begin
        pceCnt_nxt = PCE_WINDOW;
      end
      if (selWrite && pceOpen) begin
        pceCnt_nxt = PCE_CLOSED;
      end
      case (swState_r)
        SW_OLD: begin
          if (tickNow) begin
            // first edge closes a whole old period, then the new one starts
            curSel_nxt  = tgtSel_r;
            swState_nxt = SW_NEW;
          end
        end
        SW_NEW: begin
          if (tickNow) begin
            swState_nxt = SW_IDLE;
          end
        end
        default: begin
          swState_nxt = SW_IDLE;
        end
      endcase
      if (accept) begin
        // restart the old period: stretches it, never shortens it
        tgtSel_nxt  = pwdata[3:0];
        cnt_nxt     = CNT_RESET;
        swState_nxt = SW_OLD;
      end
    end
  end

  assign domainTick_nxt = {4{tickNow}};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_r       <= TRIM_RESET;
      tgtSel_r     <= SEL_DIV1;
      curSel_r     <= SEL_DIV1;
      pceCnt_r     <= PCE_CLOSED;
      cnt_r        <= CNT_RESET;
      initDone_r   <= 1'b0;
      swState_r    <= SW_IDLE;
      domainTick_r <= 4'h0;
    end else begin
      trim_r       <= trim_nxt;
      tgtSel_r     <= tgtSel_nxt;
      curSel_r     <= curSel_nxt;
      pceCnt_r     <= pceCnt_nxt;
      cnt_r        <= cnt_nxt;
      initDone_r   <= initDone_nxt;
      swState_r    <= swState_nxt;
      domainTick_r <= domainTick_nxt;
    end
  end

  // clock output pin: only power-on reset stops it, so it runs through chip reset
  logic fuseOut_r;
  logic fuseOut_nxt;
  logic clkOut_r;
  logic clkOut_nxt;
  logic clkOutOeN_r;
  logic clkOutOeN_nxt;

  always_comb begin
    fuseOut_nxt   = clockOutputFuse;
    clkOut_nxt    = portDataOut;
    clkOutOeN_nxt = portOeN;
    if (fuseOut_r) begin
      // one pin edge per divided clock edge; half the tick rate at best
      if (rst || tickNow) begin
        clkOut_nxt = ~clkOut_r;
      end else begin
        clkOut_nxt = clkOut_r;
      end
      clkOutOeN_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge powerOnRst) begin
    if (powerOnRst) begin
      fuseOut_r   <= 1'b0;
      clkOut_r    <= 1'b0;
      clkOutOeN_r <= 1'b1;
    end else begin
      fuseOut_r   <= fuseOut_nxt;
      clkOut_r    <= clkOut_nxt;
      clkOutOeN_r <= clkOutOeN_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign domainTick     = domainTick_r;
  assign clockOutPin    = clkOut_r;
  assign clockOutPinOeN = clkOutOeN_r;
  assign rcOscTrim      = trim_r;

  // helper: divided edges since a change was accepted
  logic [1:0] swEdges_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swEdges_r <= 2'h0;
    end else if (accept) begin
      swEdges_r <= 2'h0;
    end else if (swState_r != SW_IDLE && tickNow) begin
      swEdges_r <= 2'(swEdges_r + 2'h1);
    end
  end

  property p_pce_clean_only;
    @(posedge clk) disable iff (rst)
    (initDone_r && wrCtrl && pwdata[CTRL_PCE_BIT] && !cleanPce && !pceOpen) |=> !pceOpen;
  endproperty
  a_pce_clean_only: assert property (p_pce_clean_only)
    else $error("change-enable set by a dirty write");

  property p_pce_window_len;
    @(posedge clk) disable iff (rst)
    $rose(pceOpen) |-> (pceCnt_r == PCE_WINDOW);
  endproperty
  a_pce_window_len: assert property (p_pce_window_len)
    else $error("change-enable window does not start at four");

  property p_pce_timeout;
    @(posedge clk) disable iff (rst)
    (pceCnt_r == 3'h1 && tickNow && !wrCtrl) |=> !pceOpen;
  endproperty
  a_pce_timeout: assert property (p_pce_timeout)
    else $error("change-enable outlived its window");

  property p_pce_no_restart;
    @(posedge clk) disable iff (rst)
    (pceOpen && wrCtrl && cleanPce && !tickNow) |=> (pceCnt_r == $past(pceCnt_r));
  endproperty
  a_pce_no_restart: assert property (p_pce_no_restart)
    else $error("rewrite of change-enable moved the window");

  property p_sel_locked;
    @(posedge clk) disable iff (rst)
    (initDone_r && selWrite && !pceOpen) |=> $stable(tgtSel_r);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("division select changed without change-enable");

  property p_div8_period;
    @(posedge clk) disable iff (rst)
    (curSel_r == SEL_DIV8 && swState_r == SW_IDLE && tickNow && !accept) |=> !tickNow [*7];
  endproperty
  a_div8_period: assert property (p_div8_period)
    else $error("divide-by-eight period shorter than eight cycles");

  property p_two_edges;
    @(posedge clk) disable iff (rst)
    (swState_r == SW_NEW && tickNow && !accept) |-> (swEdges_r == 2'h1) ##1 (swState_r == SW_IDLE);
  endproperty
  a_two_edges: assert property (p_two_edges)
    else $error("switch did not finish on its second edge");

  property p_reset_load;
    @(posedge clk) disable iff (rst)
    $rose(initDone_r) |-> (rcOscTrim == $past(factoryTrim))
      && (tgtSel_r == ($past(divideByEightFuse) ? SEL_DIV8 : SEL_DIV1));
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("reset values not loaded from fuses");

  property p_clkout_tick;
    @(posedge clk) disable iff (powerOnRst)
    (fuseOut_r && tickNow) |=> (clockOutPin != $past(clockOutPin)) && !clockOutPinOeN;
  endproperty
  a_clkout_tick: assert property (p_clkout_tick)
    else $error("clock output pin missed a divided edge");

  property p_clkout_reset;
    @(posedge clk) disable iff (powerOnRst)
    (fuseOut_r && rst) |=> (clockOutPin != $past(clockOutPin));
  endproperty
  a_clkout_reset: assert property (p_clkout_reset)
    else $error("clock output pin stalled during reset");

endmodule

`default_nettype wire

// file: verif/scp_clk_sink.sv
`timescale 1ns/10ps
`default_nettype none

module scp_clk_sink (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // received clocks
  input  wire logic [3:0] domainTick,
  input  wire logic       clockOutPin,
  // measured spacing
  output var  int         tickGap,
  output var  int         pinGap,
  output var  int         ticks
);
  int   sinceTick;
  int   sincePin;
  logic pinLast;

  // gaps in master cycles, so one sink serves every division setting
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tickGap <= 0;
      pinGap <= 0;
      ticks <= 0;
      sinceTick <= 0;
      sincePin <= 0;
      pinLast <= 1'b0;
    end else begin
      sinceTick <= sinceTick + 1;
      sincePin <= sincePin + 1;
      pinLast <= clockOutPin;
      if (domainTick[0] === 1'b1) begin
        tickGap <= sinceTick + 1;
        sinceTick <= 0;
        ticks <= ticks + 1;
      end
      if (clockOutPin !== pinLast) begin
        pinGap <= sincePin + 1;
        sincePin <= 0;
      end
    end
  end
endmodule

`default_nettype wire

// file: verif/scp_prescaler_tb.sv
`timescale 1ns/10ps
`default_nettype none

module scp_prescaler_tb;
  import scp_pkg::*;
  logic        clk, rst, powerOnRst, psel, penable, pwrite, pready, pslverr, err, p;
  logic        clockOutputFuse, divideByEightFuse, portDataOut, portOeN;
  logic        clockOutPin, clockOutPinOeN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  factoryTrim, rcOscTrim;
  logic [3:0]  domainTick;
  int          miscompares, checkCount, tickGap, pinGap, ticks, k, cur, lo, hi;

  scp_prescaler scp_prescaler_inst (.clk(clk), .rst(rst), .powerOnRst(powerOnRst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clockOutputFuse(clockOutputFuse),
    .divideByEightFuse(divideByEightFuse), .factoryTrim(factoryTrim),
    .portDataOut(portDataOut), .portOeN(portOeN), .domainTick(domainTick),
    .clockOutPin(clockOutPin), .clockOutPinOeN(clockOutPinOeN), .rcOscTrim(rcOscTrim));

  scp_clk_sink scp_clk_sink_inst (.clk(clk), .rst(powerOnRst), .domainTick(domainTick),
    .clockOutPin(clockOutPin), .tickGap(tickGap), .pinGap(pinGap), .ticks(ticks));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // answer is taken at the very edge that samples pready high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic readCtrl(input logic [3:0] exp);
    apb(1'b0, ADDR_CTRL, 8'h00);
    check(rd, {28'h0, exp});
  endtask

  task automatic change(input logic [3:0] code);
    apb(1'b1, ADDR_CTRL, 8'h80);
    apb(1'b1, ADDR_CTRL, {4'h0, code});
  endtask

  task automatic waitTicks(input int num);
    int seen;
    seen = 0;
    k = 0;
    // a tick launched by the write's own edge predates the change
    @(negedge clk);
    while (seen < num && k < 3000) begin
      @(negedge clk);
      k++;
      if (domainTick[0] === 1'b1) seen++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // every domain enable must move in step
  always @(negedge clk) begin
    if (rst === 1'b0 && domainTick !== {4{domainTick[0]}}) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, domainTick, {4{domainTick[0]}});
    end
  end

  initial begin
    #80000;
    miscompares++;
    results();
  end

  initial begin
    {rst, powerOnRst, clockOutputFuse, divideByEightFuse, portOeN} = 5'h1F;
    {psel, penable, pwrite, portDataOut, paddr, pwdata} = '0;
    factoryTrim = 8'hA5;
    miscompares = 0;
    checkCount = 0;
    cur = 3;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    powerOnRst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_TRIM, 8'h00);
    check(rd, 32'h000000A5);
    readCtrl(4'h3);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_TRIM, 8'h7F + 8'(i));
      apb(1'b0, ADDR_TRIM, 8'h00);
      check(rd, 32'h0000007F + 32'(i));
      check({24'h0, rcOscTrim}, 32'h0000007F + 32'(i));
    end
    apb(1'b0, 12'h0FC, 8'h00);
    check({31'h0, err}, 32'h1);
    $display("register test done");
    apb(1'b1, ADDR_CTRL, 8'h05);
    readCtrl(4'h3);
    apb(1'b1, ADDR_CTRL, 8'h81);
    apb(1'b1, ADDR_CTRL, 8'h05);
    readCtrl(4'h3);
    change(4'h9);
    readCtrl(4'h3);
    // walk 1..8 then back to 0, never opening a window at divide by one
    for (int c = 1; c <= 9; c++) begin
      change(4'(c % 9));
      waitTicks(2);
      lo = (1 << cur) + (1 << (c % 9));
      hi = (1 << cur) + 2 * (1 << (c % 9));
      check({31'h0, k >= lo && k <= hi}, 32'h1);
      waitTicks(1);
      check(32'(tickGap), 32'(1 << (c % 9)));
      check(32'(pinGap), 32'(1 << (c % 9)));
      readCtrl(4'(c % 9));
      apb(1'b0, ADDR_STATUS, 8'h00);
      check(rd, 32'h00000200 | 32'((c % 9) * 17));
      cur = c % 9;
    end
    apb(1'b1, ADDR_CTRL, 8'h80);
    apb(1'b1, ADDR_CTRL, 8'h80);
    apb(1'b1, ADDR_CTRL, 8'h02);
    readCtrl(4'h0);
    apb(1'b1, ADDR_CTRL, 8'h80);
    repeat (8) @(posedge clk);
    apb(1'b1, ADDR_CTRL, 8'h02);
    readCtrl(4'h0);
    change(4'h2);
    apb(1'b1, ADDR_CTRL, 8'h01);
    readCtrl(4'h2);
    $display("divider test done");
    clockOutputFuse <= 1'b0;
    portOeN <= 1'b0;
    portDataOut <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({30'h0, clockOutPin, clockOutPinOeN}, 32'h2);
    @(posedge clk);
    clockOutputFuse <= 1'b1;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    p = clockOutPin;
    @(negedge clk);
    check({30'h0, clockOutPin, clockOutPinOeN}, {30'h0, ~p, 1'b0});
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_TRIM, 8'h00);
    check(rd, 32'h000000A5);
    readCtrl(4'h3);
    $display("pin test done");
    results();
  end
endmodule

`default_nettype wire
